// ### src/exec_regs.svh
// Opcode encodings, field positions and reset values of the execute block
`ifndef EXEC_REGS_SVH
`define EXEC_REGS_SVH

// =====================================================================
// Arithmetic opcodes
`define OPC_ADD_IMM 8'h24
`define OPC_ADD_DIR 8'h25
`define OPC_ADD_IND 7'h13
`define OPC_ADD_REG 5'h05
`define OPC_ADD_WITH_CARRY_IMM 8'h34
`define OPC_ADD_WITH_CARRY_DIR 8'h35
`define OPC_ADD_WITH_CARRY_IND 7'h1b
`define OPC_ADD_WITH_CARRY_REG 5'h07

// =====================================================================
// Logical and compare opcodes
`define OPC_AND_A_IMM 8'h54
`define OPC_AND_A_DIR 8'h55
`define OPC_AND_A_IND 7'h2b
`define OPC_AND_A_REG 5'h0b
`define OPC_AND_D_ACC 8'h52
`define OPC_AND_D_IMM 8'h53
`define OPC_AND_C_BIT 8'h82
`define OPC_AND_C_NBIT 8'hb0
`define OPC_CMP_A_IMM 8'hb4
`define OPC_CMP_A_DIR 8'hb5
`define OPC_CMP_IND 7'h5b
`define OPC_CMP_REG 5'h17

// =====================================================================
// Page-address forms, low five opcode bits
`define OPC_CALL_LOW 5'h11
`define OPC_JUMP_LOW 5'h01

// =====================================================================
// Addresses and reset values
`define BIT_RAM_BASE 8'h20
`define SP_RESET 8'h07
`define PC_RESET 16'h0000

`endif

// ### src/exec_pkg.sv
// Types shared by the execute block and its helpers
package exec_pkg;

  // ===================================================================
  // Sequencer states, one-hot
  typedef enum logic [7:0] {
    S_FETCH   = 8'h01,
    S_BYTE2   = 8'h02,
    S_BYTE3   = 8'h04,
    S_PTR     = 8'h08,
    S_OPND    = 8'h10,
    S_EXEC    = 8'h20,
    S_PUSH_LO = 8'h40,
    S_PUSH_HI = 8'h80
  } state_type;

  // ===================================================================
  // Operations and source kinds
  typedef enum logic [3:0] {
    OP_NONE, OP_CALL, OP_JUMP, OP_ADD, OP_ADD_WITH_CARRY, OP_AND_A,
    OP_AND_DA, OP_AND_DI, OP_AND_C, OP_AND_CN, OP_CMP
  } op_type;

  typedef enum logic [2:0] {
    SRC_NONE, SRC_REG, SRC_DIR, SRC_IND, SRC_IMM, SRC_BIT
  } src_type;

  typedef struct packed {
    op_type op;
    src_type src;
    logic [1:0] nbytes;
    logic [1:0] ncyc;
  } dec_type;

endpackage

// ### src/exec_if.sv
// Carrier between the sequencer, the adder and the target unit
`timescale 1ns/10ps
interface exec_if;
  logic [7:0] add_a;
  logic [7:0] add_b;
  logic add_cin;
  logic [7:0] add_sum;
  logic add_cy;
  logic add_ac;
  logic add_ov;
  logic [15:0] pc_now;
  logic [2:0] page_hi;
  logic [7:0] page_lo;
  logic [7:0] rel;
  logic [15:0] page_tgt;
  logic [15:0] rel_tgt;

  modport core (
    output add_a, add_b, add_cin, pc_now, page_hi, page_lo, rel,
    input add_sum, add_cy, add_ac, add_ov, page_tgt, rel_tgt
  );
  modport adder (
    input add_a, add_b, add_cin,
    output add_sum, add_cy, add_ac, add_ov
  );
  modport target (
    input pc_now, page_hi, page_lo, rel,
    output page_tgt, rel_tgt
  );
endinterface

// ### src/add_unit.sv
// Eight-bit adder with carry, half carry and overflow outputs
`timescale 1ns/10ps
module add_unit
  import exec_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  exec_if.adder bus
);

  logic [4:0] low;
  logic [3:0] mid;
  logic [1:0] top;

  // ===================================================================
  // Split at bits 3 and 6 so each carry is visible
  always_comb
  begin
    low = {1'b0, bus.add_a[3:0]} + {1'b0, bus.add_b[3:0]}
        + {4'h0, bus.add_cin};
    mid = {1'b0, bus.add_a[6:4]} + {1'b0, bus.add_b[6:4]}
        + {3'h0, low[4]};
    top = {1'b0, bus.add_a[7]} + {1'b0, bus.add_b[7]} + {1'b0, mid[3]};
    bus.add_sum = {top[0], mid[2:0], low[3:0]};
    bus.add_cy = top[1]; // see [RQ8]
    bus.add_ac = low[4]; // see [RQ8]
    bus.add_ov = top[1] ^ mid[3]; // see [RQ9]
  end

  property p_sum_carry;
    @(posedge clk) disable iff (sys_rst)
    {bus.add_cy, bus.add_sum} == ({1'b0, bus.add_a} + {1'b0, bus.add_b}
      + {8'h00, bus.add_cin});
  endproperty
  a_sum_carry: assert property (p_sum_carry) // see [RQ8]
    else $error("adder sum or carry out of bit 7 wrong");

  property p_overflow;
    @(posedge clk) disable iff (sys_rst)
    bus.add_ov == ((bus.add_a[7] == bus.add_b[7])
      && (bus.add_sum[7] != bus.add_a[7]));
  endproperty
  a_overflow: assert property (p_overflow) // see [RQ9]
    else $error("overflow flag disagrees with signed result");

endmodule

// ### src/branch_target.sv
// Page-relative and displacement-relative branch targets
`timescale 1ns/10ps
module branch_target
  import exec_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  exec_if.target bus
);

  // ===================================================================
  // Page target keeps the top five bits, so it never leaves the 2 K page
  always_comb
  begin
    bus.page_tgt = {bus.pc_now[15:11], bus.page_hi, bus.page_lo};
    bus.rel_tgt = bus.pc_now + {{8{bus.rel[7]}}, bus.rel}; // see [RQ16]
  end

  property p_same_page;
    @(posedge clk) disable iff (sys_rst)
    bus.page_tgt[15:11] == bus.pc_now[15:11]
      && bus.page_tgt[10:8] == bus.page_hi;
  endproperty
  a_same_page: assert property (p_same_page) // see [RQ3]
    else $error("page target left the current page");

endmodule

// ### src/cpu_call_jump_arith_exec.sv
// Fetch, decode and execute of page calls, adds, ANDs and compare-branch
// Overview of operation
// [RQ1] Call advances program counter by two; that value is the return.
// [RQ2] Call pushes return low then high byte, pre-incrementing stack.
// [RQ3] Target is upper five PC bits, opcode bits 7-5, second byte.
// [RQ4] Call is two bytes, two cycles, low pattern 10001, no flags.
// [RQ5] Jump loads the same page target and pushes nothing.
// [RQ6] Add puts accumulator plus source into accumulator.
// [RQ7] Add-with-carry sums accumulator, carry and source.
// [RQ8] Adds set carry from bit 7, auxiliary carry from bit 3.
// [RQ9] Adds set overflow when exactly one of carries 6 and 7 occurs.
// [RQ10] Adds take register, direct, indirect, immediate sources; one cycle.
// [RQ11] Byte AND stores result in destination, flags untouched.
// [RQ12] AND direct with immediate is three bytes, two cycles.
// [RQ13] Read-modify-write reads the port output latch, not pins.
// [RQ14] Bit AND clears carry on zero source bit, else keeps it.
// [RQ15] Complemented bit AND uses inverse bit, stored bit unchanged.
// [RQ16] Compare-branch advances by three, adds displacement if unequal.
// [RQ17] Compare-branch carry is unsigned first below second.
// [RQ18] Compare forms: A with direct or immediate, RAM with immediate.
// [RQ19] Direct and indirect add use 00100101 and 0010011i.
// [RQ20] Operand bytes follow the opcode; displacement comes last.
`timescale 1ns/10ps
`include "exec_regs.svh"
module cpu_call_jump_arith_exec
  import exec_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [1:0] reg_bank,
  output logic [15:0] code_addr,
  input wire logic [7:0] code_data,
  output logic [7:0] data_addr,
  input wire logic [7:0] data_rd_data,
  output logic data_rd_latch,
  output logic data_wr_en,
  output logic [7:0] data_wr_data,
  output logic [15:0] pc,
  output logic [7:0] sp,
  output logic [7:0] acc,
  output logic carry_flag,
  output logic auxiliary_carry_flag,
  output logic overflow_flag,
  output logic instr_done,
  output logic [1:0] instr_cycles,
  output logic illegal_opcode
);

  state_type state, next_state;
  logic [15:0] next_pc;
  logic [7:0] next_sp, next_acc, opc, next_opc, byte2, next_byte2;
  logic [7:0] byte3, next_byte3, ptr, next_ptr, opnd, next_opnd;
  logic next_cy, next_ac, next_ov, next_done, next_illegal;
  logic [1:0] next_cycles;
  dec_type dec, dec_new;
  logic [7:0] src_val, first, second, bit_byte, opnd_addr;
  logic bit_val;
  state_type after_bytes;
  exec_if link ();

  // ===================================================================
  // Decoder; direct and indirect add patterns precede the register form
  function automatic dec_type decode(input logic [7:0] o);
    dec_type d;
    d = '{OP_NONE, SRC_NONE, 2'd1, 2'd1};
    casez (o)
      {3'b???, `OPC_CALL_LOW}: d = '{OP_CALL, SRC_NONE, 2'd2, 2'd2};
      {3'b???, `OPC_JUMP_LOW}: d = '{OP_JUMP, SRC_NONE, 2'd2, 2'd2};
      `OPC_ADD_IMM: d = '{OP_ADD, SRC_IMM, 2'd2, 2'd1};
      `OPC_ADD_DIR: d = '{OP_ADD, SRC_DIR, 2'd2, 2'd1}; // see [RQ19]
      {`OPC_ADD_IND, 1'b?}: d = '{OP_ADD, SRC_IND, 2'd1, 2'd1}; // see [RQ19]
      {`OPC_ADD_REG, 3'b???}: d = '{OP_ADD, SRC_REG, 2'd1, 2'd1};
      `OPC_ADD_WITH_CARRY_IMM: d = '{OP_ADD_WITH_CARRY, SRC_IMM, 2'd2, 2'd1};
      `OPC_ADD_WITH_CARRY_DIR: d = '{OP_ADD_WITH_CARRY, SRC_DIR, 2'd2, 2'd1};
      {`OPC_ADD_WITH_CARRY_IND, 1'b?}: d = '{OP_ADD_WITH_CARRY, SRC_IND, 2'd1, 2'd1};
      {`OPC_ADD_WITH_CARRY_REG, 3'b???}: d = '{OP_ADD_WITH_CARRY, SRC_REG, 2'd1, 2'd1};
      `OPC_AND_A_IMM: d = '{OP_AND_A, SRC_IMM, 2'd2, 2'd1};
      `OPC_AND_A_DIR: d = '{OP_AND_A, SRC_DIR, 2'd2, 2'd1};
      {`OPC_AND_A_IND, 1'b?}: d = '{OP_AND_A, SRC_IND, 2'd1, 2'd1};
      {`OPC_AND_A_REG, 3'b???}: d = '{OP_AND_A, SRC_REG, 2'd1, 2'd1};
      `OPC_AND_D_ACC: d = '{OP_AND_DA, SRC_DIR, 2'd2, 2'd1};
      `OPC_AND_D_IMM: d = '{OP_AND_DI, SRC_DIR, 2'd3, 2'd2}; // see [RQ12]
      `OPC_AND_C_BIT: d = '{OP_AND_C, SRC_BIT, 2'd2, 2'd2};
      `OPC_AND_C_NBIT: d = '{OP_AND_CN, SRC_BIT, 2'd2, 2'd2};
      `OPC_CMP_A_IMM: d = '{OP_CMP, SRC_IMM, 2'd3, 2'd2}; // see [RQ18]
      `OPC_CMP_A_DIR: d = '{OP_CMP, SRC_DIR, 2'd3, 2'd2};
      {`OPC_CMP_IND, 1'b?}: d = '{OP_CMP, SRC_IND, 2'd3, 2'd2};
      {`OPC_CMP_REG, 3'b???}: d = '{OP_CMP, SRC_REG, 2'd3, 2'd2};
      default: d = '{OP_NONE, SRC_NONE, 2'd1, 2'd1};
    endcase
    return d;
  endfunction

  add_unit u_add (
    .clk(clk),
    .sys_rst(sys_rst),
    .bus(link.adder)
  );

  branch_target u_tgt (
    .clk(clk),
    .sys_rst(sys_rst),
    .bus(link.target)
  );

  // ===================================================================
  // Operand selection for the adder, the compare and the bit forms
  always_comb
  begin
    dec = decode(opc);
    dec_new = decode(code_data);
    // Bit addresses below 80h live in the bit-addressable RAM bytes
    bit_byte = byte2[7] ? {byte2[7:3], 3'b000}
                        : (`BIT_RAM_BASE + {4'h0, byte2[6:3]});
    bit_val = opnd[byte2[2:0]];
    src_val = (dec.src == SRC_IMM) ? byte2 : opnd;
    // Working-register forms compare RAM against the immediate
    first = (dec.src == SRC_IND || dec.src == SRC_REG) ? opnd : acc;
    second = (dec.src == SRC_DIR) ? opnd : byte2; // see [RQ18]
    case (dec.src)
      SRC_REG: opnd_addr = {3'b000, reg_bank, opc[2:0]};
      SRC_IND: opnd_addr = ptr;
      SRC_BIT: opnd_addr = bit_byte;
      default: opnd_addr = byte2;
    endcase
    case (dec.src)
      SRC_IND: after_bytes = S_PTR;
      SRC_REG, SRC_DIR, SRC_BIT: after_bytes = S_OPND;
      default: after_bytes = S_EXEC;
    endcase
    link.add_a = acc;
    link.add_b = src_val;
    link.add_cin = (dec.op == OP_ADD_WITH_CARRY) ? carry_flag : 1'b0; // see [RQ7]
    link.pc_now = pc;
    link.page_hi = opc[7:5]; // see [RQ3]
    link.page_lo = byte2;
    link.rel = byte3; // see [RQ20]
  end

  // ===================================================================
  // Memory strobes; addresses are combinational so reads land this cycle
  always_comb
  begin
    code_addr = pc;
    data_addr = 8'h00;
    data_rd_latch = 1'b0;
    data_wr_en = 1'b0;
    data_wr_data = 8'h00;
    case (state)
      S_PTR: data_addr = {3'b000, reg_bank, 2'b00, opc[0]};
      S_OPND:
      begin
        data_addr = opnd_addr;
        // Port reads for read-modify-write take the output latch
        data_rd_latch = (dec.op == OP_AND_DA)
                     || (dec.op == OP_AND_DI); // see [RQ13]
      end
      S_EXEC:
      begin
        data_addr = byte2;
        data_wr_en = (dec.op == OP_AND_DA) || (dec.op == OP_AND_DI);
        data_wr_data = opnd & ((dec.op == OP_AND_DI) ? byte3 : acc);
      end
      S_PUSH_LO:
      begin
        data_addr = sp + 8'h01; // see [RQ2]
        data_wr_en = 1'b1;
        data_wr_data = pc[7:0];
      end
      S_PUSH_HI:
      begin
        data_addr = sp + 8'h01; // see [RQ2]
        data_wr_en = 1'b1;
        data_wr_data = pc[15:8];
      end
      default: data_addr = 8'h00;
    endcase
  end

  // ===================================================================
  // Sequencer next state and architectural next values
  always_comb
  begin
    next_state = state;
    next_pc = pc;
    next_sp = sp;
    next_acc = acc;
    next_cy = carry_flag;
    next_ac = auxiliary_carry_flag;
    next_ov = overflow_flag;
    next_opc = opc;
    next_byte2 = byte2;
    next_byte3 = byte3;
    next_ptr = ptr;
    next_opnd = opnd;
    next_done = 1'b0;
    next_illegal = 1'b0;
    next_cycles = instr_cycles;
    case (state)
      S_FETCH:
      begin
        next_opc = code_data;
        next_pc = pc + 16'h0001;
        if (dec_new.nbytes != 2'd1)
          next_state = S_BYTE2;
        else if (dec_new.src == SRC_IND)
          next_state = S_PTR;
        else if (dec_new.src == SRC_REG)
          next_state = S_OPND;
        else
          next_state = S_EXEC;
      end
      S_BYTE2:
      begin
        // Each fetched byte advances the counter: call ends at PC+2
        next_byte2 = code_data; // see [RQ20]
        next_pc = pc + 16'h0001; // see [RQ1]
        next_state = (dec.nbytes == 2'd3) ? S_BYTE3 : after_bytes;
      end
      S_BYTE3:
      begin
        next_byte3 = code_data; // see [RQ20]
        next_pc = pc + 16'h0001; // see [RQ16]
        next_state = after_bytes;
      end
      S_PTR:
      begin
        next_ptr = data_rd_data;
        next_state = S_OPND;
      end
      S_OPND:
      begin
        next_opnd = data_rd_data;
        next_state = S_EXEC;
      end
      S_EXEC:
      begin
        next_state = S_FETCH;
        next_done = 1'b1;
        next_cycles = dec.ncyc; // see [RQ10]
        case (dec.op)
          OP_CALL:
          begin
            next_state = S_PUSH_LO; // see [RQ4]
            next_done = 1'b0;
          end
          OP_JUMP: next_pc = link.page_tgt; // see [RQ5]
          OP_ADD, OP_ADD_WITH_CARRY:
          begin
            next_acc = link.add_sum; // see [RQ6]
            next_cy = link.add_cy; // see [RQ8]
            next_ac = link.add_ac;
            next_ov = link.add_ov; // see [RQ9]
          end
          OP_AND_A: next_acc = acc & src_val; // see [RQ11]
          OP_AND_C: next_cy = carry_flag & bit_val; // see [RQ14]
          OP_AND_CN: next_cy = carry_flag & ~bit_val; // see [RQ15]
          OP_CMP:
          begin
            next_cy = first < second; // see [RQ17]
            if (first != second)
              next_pc = link.rel_tgt; // see [RQ16]
          end
          OP_NONE: next_illegal = 1'b1;
          default: next_done = 1'b1;
        endcase
      end
      S_PUSH_LO:
      begin
        next_sp = sp + 8'h01;
        next_state = S_PUSH_HI;
      end
      S_PUSH_HI:
      begin
        next_sp = sp + 8'h01;
        next_pc = link.page_tgt; // see [RQ3]
        next_state = S_FETCH;
        next_done = 1'b1;
        next_cycles = dec.ncyc;
      end
      default: next_state = S_FETCH;
    endcase
  end

  // ===================================================================
  // State registers
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      state <= S_FETCH;
      pc <= `PC_RESET;
      sp <= `SP_RESET;
      acc <= 8'h00;
      carry_flag <= 1'b0;
      auxiliary_carry_flag <= 1'b0;
      overflow_flag <= 1'b0;
      opc <= 8'h00;
      byte2 <= 8'h00;
      byte3 <= 8'h00;
      ptr <= 8'h00;
      opnd <= 8'h00;
      instr_done <= 1'b0;
      instr_cycles <= 2'd0;
      illegal_opcode <= 1'b0;
    end
    else
    begin
      state <= next_state;
      pc <= next_pc;
      sp <= next_sp;
      acc <= next_acc;
      carry_flag <= next_cy;
      auxiliary_carry_flag <= next_ac;
      overflow_flag <= next_ov;
      opc <= next_opc;
      byte2 <= next_byte2;
      byte3 <= next_byte3;
      ptr <= next_ptr;
      opnd <= next_opnd;
      instr_done <= next_done;
      instr_cycles <= next_cycles;
      illegal_opcode <= next_illegal;
    end
  end

  // ===================================================================
  // Checks
  property p_push_lo;
    @(posedge clk) disable iff (sys_rst)
    state == S_PUSH_LO |-> data_wr_en && data_wr_data == pc[7:0]
      ##1 data_wr_en && data_wr_data == $past(pc[15:8]);
  endproperty
  a_push_lo: assert property (p_push_lo) // see [RQ2]
    else $error("return address not pushed low byte first");

  property p_call_sp;
    @(posedge clk) disable iff (sys_rst)
    state == S_PUSH_LO |=> ##1 sp == $past(sp, 2) + 8'h02;
  endproperty
  a_call_sp: assert property (p_call_sp) // see [RQ2]
    else $error("stack pointer did not grow by two on call");

  property p_call_tgt;
    @(posedge clk) disable iff (sys_rst)
    state == S_PUSH_HI |=> pc == {$past(pc[15:11]), $past(opc[7:5]),
      $past(byte2)} && carry_flag == $past(carry_flag);
  endproperty
  a_call_tgt: assert property (p_call_tgt) // see [RQ3]
    else $error("call target or flags wrong");

  property p_jump_nopush;
    @(posedge clk) disable iff (sys_rst)
    state == S_EXEC && dec.op == OP_JUMP |-> !data_wr_en
      ##1 state == S_FETCH && sp == $past(sp);
  endproperty
  a_jump_nopush: assert property (p_jump_nopush) // see [RQ5]
    else $error("jump touched the stack");

  property p_and_flags;
    @(posedge clk) disable iff (sys_rst)
    state == S_EXEC && (dec.op == OP_AND_A || dec.op == OP_AND_DI)
      |=> carry_flag == $past(carry_flag) && overflow_flag
      == $past(overflow_flag);
  endproperty
  a_and_flags: assert property (p_and_flags) // see [RQ11]
    else $error("byte AND changed a flag");

  property p_rmw_latch;
    @(posedge clk) disable iff (sys_rst)
    state == S_EXEC && data_wr_en && dec.op != OP_CALL
      |-> $past(data_rd_latch) && $past(state) == S_OPND;
  endproperty
  a_rmw_latch: assert property (p_rmw_latch) // see [RQ13]
    else $error("read-modify-write did not read the latch");

  property p_bit_and;
    @(posedge clk) disable iff (sys_rst)
    state == S_EXEC && dec.op == OP_AND_C && !bit_val |=> !carry_flag;
  endproperty
  a_bit_and: assert property (p_bit_and) // see [RQ14]
    else $error("bit AND kept carry on zero source");

  property p_cmp_carry;
    @(posedge clk) disable iff (sys_rst)
    state == S_EXEC && dec.op == OP_CMP
      |=> carry_flag == ($past(first) < $past(second))
      && acc == $past(acc);
  endproperty
  a_cmp_carry: assert property (p_cmp_carry) // see [RQ17]
    else $error("compare carry wrong or operand changed");

  property p_cmp_equal;
    @(posedge clk) disable iff (sys_rst)
    state == S_EXEC && dec.op == OP_CMP && first == second
      |=> pc == $past(pc);
  endproperty
  a_cmp_equal: assert property (p_cmp_equal) // see [RQ16]
    else $error("compare branched on equal operands");

endmodule

// ### testbench/mem_model.sv
// Program memory and internal data RAM facing the execute block
`timescale 1ns/10ps
module mem_model
(
  input wire logic clk,
  input wire logic [15:0] code_addr,
  output logic [7:0] code_data,
  input wire logic [7:0] data_addr,
  output logic [7:0] data_rd_data,
  input wire logic data_rd_latch,
  input wire logic data_wr_en,
  input wire logic [7:0] data_wr_data
);
  // =====================================================================
  // Storage
  logic [7:0] code_mem [0:65535];
  logic [7:0] ram [0:255];

  // Unwritten code reads as zero, an opcode outside this set
  initial
  begin
    for (int i = 0; i < 65536; i++)
      code_mem[i] = 8'h00;
    for (int i = 0; i < 256; i++)
      ram[i] = 8'h00;
  end

  // Reads answer in the same cycle, as the block expects
  assign code_data = code_mem[code_addr];
  // Pins at 80h and up read inverted so a pin read is never mistaken for latch
  assign data_rd_data = (data_addr[7] && !data_rd_latch) ?
    ~ram[data_addr] : ram[data_addr];

  // One byte per strobe; plain always so the bench may preload bytes
  always @(posedge clk)
  begin
    if (data_wr_en)
      ram[data_addr] <= data_wr_data;
  end
endmodule

// ### testbench/testbench.sv
// Self-checking bench for the call, jump, add, AND and compare block
`timescale 1ns/10ps
module testbench;
  import exec_pkg::*;
  logic clk;
  logic sys_rst;
  logic [1:0] reg_bank;
  logic [15:0] code_addr;
  logic [7:0] code_data;
  logic [7:0] data_addr;
  logic [7:0] data_rd_data;
  logic data_rd_latch;
  logic data_wr_en;
  logic [7:0] data_wr_data;
  logic [15:0] pc;
  logic [7:0] sp;
  logic [7:0] acc;
  logic carry_flag;
  logic auxiliary_carry_flag;
  logic overflow_flag;
  logic instr_done;
  logic [1:0] instr_cycles;
  logic illegal_opcode;
  int fail_count;
  int checked;
  logic [15:0] wp;
  logic [7:0] m_acc;
  logic m_cy;
  logic m_ac;
  logic m_ov;

  // =====================================================================
  // Block and its memories
  cpu_call_jump_arith_exec u_cpu_call_jump_arith_exec (
    .clk(clk),
    .sys_rst(sys_rst),
    .reg_bank(reg_bank),
    .code_addr(code_addr),
    .code_data(code_data),
    .data_addr(data_addr),
    .data_rd_data(data_rd_data),
    .data_rd_latch(data_rd_latch),
    .data_wr_en(data_wr_en),
    .data_wr_data(data_wr_data),
    .pc(pc),
    .sp(sp),
    .acc(acc),
    .carry_flag(carry_flag),
    .auxiliary_carry_flag(auxiliary_carry_flag),
    .overflow_flag(overflow_flag),
    .instr_done(instr_done),
    .instr_cycles(instr_cycles),
    .illegal_opcode(illegal_opcode)
  );

  mem_model u_mem (
    .clk(clk),
    .code_addr(code_addr),
    .code_data(code_data),
    .data_addr(data_addr),
    .data_rd_data(data_rd_data),
    .data_rd_latch(data_rd_latch),
    .data_wr_en(data_wr_en),
    .data_wr_data(data_wr_data)
  );

  // 50 ns clock
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // =====================================================================
  // Shared helpers
  task finish_test;
    $display("Checks %0d, mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task chk(input string what, input logic [15:0] exp,
           input logic [15:0] got);
    checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Code bytes land before the fetch that reads them
  task put(input logic [7:0] b);
    u_mem.code_mem[wp] = b;
    wp++;
  endtask

  // Waits for completion, bounded, then checks length and next address
  task run(input logic [1:0] cyc);
    int n;
    n = 0;
    @(negedge clk);
    while (instr_done !== 1'b1 && n < 12)
    begin
      @(negedge clk);
      n++;
    end
    chk("done", 16'h0001, {15'h0, instr_done});
    chk("cycles", {14'h0, cyc}, {14'h0, instr_cycles});
    chk("pc", wp, pc);
  endtask

  task flags;
    chk("acc", {8'h00, m_acc}, {8'h00, acc});
    chk("cy", {15'h0, m_cy}, {15'h0, carry_flag});
    chk("ac", {15'h0, m_ac}, {15'h0, auxiliary_carry_flag});
    chk("ov", {15'h0, m_ov}, {15'h0, overflow_flag});
  endtask

  // Reference sum with carries out of bits 3, 6 and 7
  task add1(input logic [7:0] opc, input logic [7:0] opr,
            input logic two, input logic usec, input logic [7:0] src);
    logic [8:0] s;
    logic [4:0] h;
    logic [7:0] l;
    put(opc);
    if (two)
      put(opr);
    s = {1'b0, m_acc} + {1'b0, src} + {8'h00, usec};
    h = {1'b0, m_acc[3:0]} + {1'b0, src[3:0]} + {4'h0, usec};
    l = {1'b0, m_acc[6:0]} + {1'b0, src[6:0]} + {7'h0, usec};
    m_acc = s[7:0];
    m_cy = s[8];
    m_ac = h[4];
    m_ov = s[8] ^ l[7];
    run(2'h1);
    flags;
  endtask

  task bit1(input logic [7:0] opc, input logic [7:0] badr, input logic v);
    put(opc);
    put(badr);
    m_cy = m_cy & ((opc == 8'h82) ? v : ~v);
    run(2'h2);
    flags;
  endtask

  // Operand order: opcode, operand, displacement last
  task cmp(input logic [7:0] opc, input logic [7:0] b2,
           input logic [7:0] rel, input logic [7:0] a,
           input logic [7:0] b);
    put(opc);
    put(b2);
    put(rel);
    m_cy = a < b;
    if (a != b)
      wp = wp + {{8{rel[7]}}, rel};
    run(2'h2);
    flags;
  endtask

  // =====================================================================
  // Scenarios
  task t_jump_call;
    wp = 16'h0123;
    run(2'h2);
    chk("sp", 16'h0007, {8'h00, sp});
    put(8'h71);
    put(8'h45);
    wp = 16'h0345;
    run(2'h2);
    chk("sp", 16'h0009, {8'h00, sp});
    chk("lo", 16'h0025, {8'h00, u_mem.ram[8'h08]});
    chk("hi", 16'h0001, {8'h00, u_mem.ram[8'h09]});
    flags;
  endtask

  task t_add;
    u_mem.ram[8'h00] = 8'haa;
    u_mem.ram[8'h01] = 8'h30;
    u_mem.ram[8'h30] = 8'haa;
    u_mem.ram[8'h12] = 8'h55;
    u_mem.ram[8'h50] = 8'h81;
    add1(8'h24, 8'hc3, 1'b1, 1'b0, 8'hc3);
    add1(8'h28, 8'h00, 1'b0, 1'b0, 8'haa);
    add1(8'h37, 8'h00, 1'b0, m_cy, 8'haa);
    add1(8'h25, 8'h30, 1'b1, 1'b0, 8'haa);
    add1(8'h34, 8'h3e, 1'b1, m_cy, 8'h3e);
    add1(8'h35, 8'h30, 1'b1, m_cy, 8'haa);
    reg_bank = 2'h2;
    add1(8'h3a, 8'h00, 1'b0, m_cy, 8'h55);
    reg_bank = 2'h0;
    u_mem.ram[8'h00] = 8'h50;
    add1(8'h26, 8'h00, 1'b0, 1'b0, 8'h81);
  endtask

  task t_and;
    u_mem.ram[8'h03] = 8'h55;
    u_mem.ram[8'h40] = 8'h03;
    u_mem.ram[8'h90] = 8'h3c;
    put(8'h5b);
    m_acc = m_acc & 8'h55;
    run(2'h1);
    flags;
    put(8'h52);
    put(8'h40);
    run(2'h1);
    chk("and", {8'h00, 8'h03 & m_acc}, {8'h00, u_mem.ram[8'h40]});
    put(8'h53);
    put(8'h90);
    put(8'h0f);
    run(2'h2);
    chk("port", 16'h000c, {8'h00, u_mem.ram[8'h90]});
    flags;
    add1(8'h24, 8'hff, 1'b1, 1'b0, 8'hff);
    u_mem.ram[8'h20] = 8'h00;
    u_mem.ram[8'h21] = 8'h02;
    bit1(8'hb0, 8'h00, 1'b0);
    bit1(8'h82, 8'h09, 1'b1);
    bit1(8'hb0, 8'h09, 1'b1);
    chk("bit", 16'h0002, {8'h00, u_mem.ram[8'h21]});
  endtask

  task t_cmp;
    u_mem.ram[8'h07] = 8'h60;
    cmp(8'hb4, m_acc, 8'h05, m_acc, m_acc);
    cmp(8'hb4, 8'hff, 8'h05, m_acc, 8'hff);
    // Carry is set here, so a zero source bit must clear it
    bit1(8'h82, 8'h00, 1'b0);
    cmp(8'hb5, 8'h30, 8'hf0, m_acc, 8'haa);
    cmp(8'hbf, 8'h40, 8'h04, 8'h60, 8'h40);
    cmp(8'hb6, 8'h81, 8'h7f, 8'h81, 8'h81);
    chk("opnd", 16'h0081, {8'h00, u_mem.ram[8'h50]});
  endtask

  task t_reset;
    sys_rst = 1'b1;
    repeat (2) @(negedge clk);
    chk("rpc", 16'h0000, pc);
    chk("rsp", 16'h0007, {8'h00, sp});
    chk("racc", 16'h0000, {8'h00, acc});
    // Restart from zero: the preloaded page jump must run again
    sys_rst = 1'b0;
    wp = 16'h0123;
    run(2'h2);
    // Opcode outside the set is a one-byte step that raises the flag
    put(8'h00);
    run(2'h1);
    chk("ill", 16'h0001, {15'h0, illegal_opcode});
  endtask

  // Main sequence; reset held two cycles with the first jump preloaded
  initial
  begin
    sys_rst = 1'b1;
    reg_bank = 2'h0;
    fail_count = 0;
    checked = 0;
    wp = 16'h0000;
    m_acc = 8'h00;
    m_cy = 1'b0;
    m_ac = 1'b0;
    m_ov = 1'b0;
    repeat (2) @(negedge clk);
    put(8'h21);
    put(8'h23);
    sys_rst = 1'b0;
    t_jump_call;
    t_add;
    t_and;
    t_cmp;
    t_reset;
    finish_test;
  end

  // Watchdog, well past the hundred or so cycles the run needs
  initial
  begin
    #(50 * 2000);
    fail_count++;
    finish_test;
  end
endmodule
